//--- hdl/twmr_defines.svh
// Register offsets, field positions, status codes, reset values and timing of the two-wire master
//
// Contract
// - Master mode begins only after a START
// - START waits until the bus is free
// - After START: flag set, status 0x08
// - Transfer paused while pending flag stays set
// - After read address: 0x38, 0x40 or 0x48
// - Received byte readable when flag sets
// - Repeated START: no STOP, status 0x10, keep bus
// - At 0x10 send loaded address, either direction
// - Arbitration lost: 0x38, release or restart
// - At 0x40 receive byte, ack by enable
// - At 0x48 restart, stop, or stop+start
// - At 0x50 receive another byte, ack by enable
// - At 0x58 restart, stop, or stop+start
// - Hardware clears stop request after STOP sent
`ifndef TWMR_DEFINES_SVH
`define TWMR_DEFINES_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define TWMR_OFS_CONTROL 8'h00
`define TWMR_OFS_STATUS 8'h04
`define TWMR_OFS_DATA 8'h08

// ****************************************************************
// Control and status field positions
// ****************************************************************
`define TWMR_CB_PENDING 7
`define TWMR_CB_ACK_ENABLE 6
`define TWMR_CB_START 5
`define TWMR_CB_STOP 4
`define TWMR_CB_WCOL 3
`define TWMR_CB_ENABLE 2
`define TWMR_CB_IRQ_ENABLE 0
`define TWMR_SB_PRESCALER 1:0

// ****************************************************************
// Status codes
// ****************************************************************
`define TWMR_SC_START 8'h08
`define TWMR_SC_REP_START 8'h10
`define TWMR_SC_AW_ACK 8'h18
`define TWMR_SC_AW_NACK 8'h20
`define TWMR_SC_DT_ACK 8'h28
`define TWMR_SC_DT_NACK 8'h30
`define TWMR_SC_ARB_LOST 8'h38
`define TWMR_SC_AR_ACK 8'h40
`define TWMR_SC_AR_NACK 8'h48
`define TWMR_SC_RX_ACK 8'h50
`define TWMR_SC_RX_NACK 8'h58
`define TWMR_SC_IDLE 8'hf8

// ****************************************************************
// Reset values and timing
// ****************************************************************
`define TWMR_CONTROL_RST 8'h00
`define TWMR_STATUS_RST 8'hf8
`define TWMR_DATA_RST 8'hff
`define TWMR_CLK_NS 50
`define TWMR_QUARTER_NS 100
`define TWMR_QUARTER_CYC ((`TWMR_QUARTER_NS + `TWMR_CLK_NS - 1) / `TWMR_CLK_NS)

`endif

//--- hdl/twmr_pkg.sv
// Types shared by the two-wire master engine
package twmr_pkg;

  // Control register layout, bit 7 down to bit 0
  typedef struct packed {
    logic pending;
    logic ack_enable;
    logic start_request;
    logic stop_request;
    logic write_collision;
    logic interface_enable;
    logic reserved;
    logic interrupt_enable;
  } twmr_ctrl_t;

  // Bus engine states
  typedef enum logic [3:0] {
    TWMR_IDLE,
    TWMR_WAIT_FREE,
    TWMR_START_HI,
    TWMR_START_LO,
    TWMR_PAUSE,
    TWMR_BIT_LOW,
    TWMR_BIT_SETUP,
    TWMR_BIT_RISE,
    TWMR_BIT_HIGH,
    TWMR_STOP_LO,
    TWMR_STOP_RISE,
    TWMR_STOP_HI,
    TWMR_RS_LO,
    TWMR_RS_RISE
  } twmr_state_t;

  // Kind of byte being shifted
  typedef enum logic [1:0] {
    TWMR_PH_ADDR,
    TWMR_PH_TXD,
    TWMR_PH_RXD
  } twmr_phase_t;

endpackage

//--- hdl/twmr_top.sv
// Two-wire master engine with receive path, APB register slave and bus line drivers
`timescale 1ns/1ps
`default_nettype none
`include "twmr_defines.svh"

module twmr_top import twmr_pkg::*; #(
  parameter int ADDR_W = 8,
  parameter int QUARTER_CYC = `TWMR_QUARTER_CYC
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic scl_in_i,
  output logic scl_out_o,
  output logic scl_oe_o,
  input wire logic sda_in_i,
  output logic sda_out_o,
  output logic sda_oe_o
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  twmr_ctrl_t ctrl;
  logic [7:0] status_code;
  logic [1:0] prescaler;
  logic [7:0] data;
  twmr_state_t state;
  twmr_phase_t phase;
  logic [15:0] qcnt;
  logic tick;
  logic [3:0] bitcnt;
  logic [8:0] tx9;
  logic [7:0] rxb;
  logic dir_read;
  logic own;
  logic restart_after_stop;
  logic ev_pulse;
  logic ev_load;
  logic [7:0] ev_code;
  logic [7:0] ev_data;
  logic stop_done;
  logic scl_s1, scl_s2, scl_s3, scl_f;
  logic sda_s1, sda_s2, sda_s3, sda_f, sda_fd;
  logic busy;

  // ****************************************************************
  // APB decode
  // ****************************************************************
  wire logic [7:0] addr8 = paddr_i[7:0];
  wire logic hi_zero = (ADDR_W > 8) ? (paddr_i >> 8) == '0 : 1'b1;
  wire logic hit_ctrl = hi_zero && addr8 == `TWMR_OFS_CONTROL;
  wire logic hit_stat = hi_zero && addr8 == `TWMR_OFS_STATUS;
  wire logic hit_data = hi_zero && addr8 == `TWMR_OFS_DATA;
  wire logic hit = hit_ctrl || hit_stat || hit_data;
  wire logic acc = psel_i && penable_i && pready_o;
  wire logic wr_ctrl = acc && pwrite_i && hit_ctrl;
  wire logic wr_stat = acc && pwrite_i && hit_stat;
  wire logic wr_data = acc && pwrite_i && hit_data;
  wire logic [7:0] status_rd = {status_code[7:3], 1'b0, prescaler};
  wire logic [7:0] rd_byte = hit_ctrl ? ctrl : hit_stat ? status_rd : hit_data ? data : 8'h00;

  // Engine decisions
  wire logic clear_req = wr_ctrl && pwdata_i[`TWMR_CB_PENDING];
  wire logic resume = !ctrl.pending && !ev_pulse;
  wire logic ack_seen = !sda_f;
  wire logic arb_lost = tx9[8] && !sda_f && ((phase == TWMR_PH_RXD) == (bitcnt == 4'd8));
  wire logic code_rx = status_code == `TWMR_SC_AR_ACK || status_code == `TWMR_SC_RX_ACK;
  wire logic code_tx = status_code == `TWMR_SC_AW_ACK || status_code == `TWMR_SC_AW_NACK ||
                       status_code == `TWMR_SC_DT_ACK || status_code == `TWMR_SC_DT_NACK;
  wire logic code_addr = status_code == `TWMR_SC_START || status_code == `TWMR_SC_REP_START;

  // Status code for the acknowledge bit just finished
  function automatic logic [7:0] byte_code(input twmr_phase_t ph, input logic rd,
                                           input logic ack);
    logic [7:0] c;
    c = 8'h00;
    unique case (ph)
      TWMR_PH_ADDR: c = rd ? (ack ? `TWMR_SC_AR_ACK : `TWMR_SC_AR_NACK)
                           : (ack ? `TWMR_SC_AW_ACK : `TWMR_SC_AW_NACK);
      TWMR_PH_TXD: c = ack ? `TWMR_SC_DT_ACK : `TWMR_SC_DT_NACK;
      default: c = ack ? `TWMR_SC_RX_ACK : `TWMR_SC_RX_NACK;
    endcase
    return c;
  endfunction

  // ****************************************************************
  // APB slave, one wait state per access
  // ****************************************************************
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
    end else if (psel_i && penable_i && !pready_o) begin
      pready_o <= 1'b1;
      pslverr_o <= !hit;
      prdata_o <= {24'h00_0000, rd_byte};
    end else begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end
  end

  // ****************************************************************
  // Control, status and data registers
  // ****************************************************************
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      ctrl <= `TWMR_CONTROL_RST;
    end else begin
      if (ev_pulse) begin
        ctrl.pending <= 1'b1;
      end else if (clear_req) begin
        ctrl.pending <= 1'b0;
      end
      if (wr_ctrl) begin
        ctrl.ack_enable <= pwdata_i[`TWMR_CB_ACK_ENABLE];
        ctrl.start_request <= pwdata_i[`TWMR_CB_START];
        ctrl.stop_request <= pwdata_i[`TWMR_CB_STOP];
        ctrl.interface_enable <= pwdata_i[`TWMR_CB_ENABLE];
        ctrl.interrupt_enable <= pwdata_i[`TWMR_CB_IRQ_ENABLE];
      end else if (stop_done) begin
        ctrl.stop_request <= 1'b0;
      end
      // Data write while the engine runs is a collision
      if (wr_data) begin
        ctrl.write_collision <= !ctrl.pending;
      end
    end
  end

  // Status code and received byte land with the flag
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      status_code <= `TWMR_STATUS_RST;
      prescaler <= 2'b00;
      data <= `TWMR_DATA_RST;
    end else begin
      if (ev_pulse) begin
        status_code <= ev_code;
      end
      if (wr_stat) begin
        prescaler <= pwdata_i[`TWMR_SB_PRESCALER];
      end
      if (ev_pulse && ev_load) begin
        data <= ev_data;
      end else if (wr_data && ctrl.pending) begin
        data <= pwdata_i[7:0];
      end
    end
  end

  // ****************************************************************
  // Line synchronisers and bus monitor
  // ****************************************************************
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      {scl_s1, scl_s2, scl_s3, scl_f} <= 4'hf;
      {sda_s1, sda_s2, sda_s3, sda_f} <= 4'hf;
    end else begin
      {scl_s1, scl_s2, scl_s3} <= {scl_in_i, scl_s1, scl_s2};
      {sda_s1, sda_s2, sda_s3} <= {sda_in_i, sda_s1, sda_s2};
      if (scl_s2 == scl_s3) scl_f <= scl_s3;
      if (sda_s2 == sda_s3) sda_f <= sda_s3;
    end
  end

  // START marks the bus busy, STOP frees it
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      sda_fd <= 1'b1;
      busy <= 1'b0;
    end else begin
      sda_fd <= sda_f;
      if (scl_f && sda_fd && !sda_f) begin
        busy <= 1'b1;
      end else if (scl_f && !sda_fd && sda_f) begin
        busy <= 1'b0;
      end
    end
  end

  // Quarter bit period divider
  always_ff @(posedge mclk_i) begin
    if (reset_i || qcnt == 16'(QUARTER_CYC - 1)) begin
      qcnt <= 16'h0000;
    end else begin
      qcnt <= qcnt + 16'h0001;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) tick <= 1'b0;
    else tick <= qcnt == 16'(QUARTER_CYC - 1);
  end

  // ****************************************************************
  // Bus engine
  // ****************************************************************
  always_ff @(posedge mclk_i) begin
    if (reset_i || !ctrl.interface_enable) begin
      state <= TWMR_IDLE;
      phase <= TWMR_PH_ADDR;
      bitcnt <= 4'h0;
      tx9 <= 9'h1ff;
      rxb <= 8'h00;
      dir_read <= 1'b0;
      own <= 1'b0;
      restart_after_stop <= 1'b0;
      ev_pulse <= 1'b0;
      ev_load <= 1'b0;
      ev_code <= `TWMR_SC_IDLE;
      ev_data <= 8'h00;
      stop_done <= 1'b0;
      scl_oe_o <= 1'b0;
      sda_oe_o <= 1'b0;
    end else begin
      ev_pulse <= 1'b0;
      ev_load <= 1'b0;
      stop_done <= 1'b0;
      unique case (state)
        TWMR_IDLE: begin
          if (ctrl.start_request && !ctrl.pending) state <= TWMR_WAIT_FREE;
        end
        TWMR_WAIT_FREE: begin
          // Never cut into someone else's transfer
          if (tick && !busy && scl_f && sda_f) begin
            sda_oe_o <= 1'b1;
            state <= TWMR_START_HI;
          end
        end
        TWMR_START_HI: begin
          if (tick) begin
            scl_oe_o <= 1'b1;
            state <= TWMR_START_LO;
          end
        end
        TWMR_START_LO: begin
          if (tick) begin
            ev_pulse <= 1'b1;
            ev_code <= own ? `TWMR_SC_REP_START : `TWMR_SC_START;
            own <= 1'b1;
            state <= TWMR_PAUSE;
          end
        end
        TWMR_PAUSE: begin
          // Held here, clock low except after lost arbitration, until software clears the flag
          if (resume) begin
            bitcnt <= 4'h0;
            if (status_code == `TWMR_SC_ARB_LOST) begin
              state <= ctrl.start_request ? TWMR_WAIT_FREE : TWMR_IDLE;
            end else if (code_addr) begin
              // Direction bit picks transmit or receive mode
              tx9 <= {data, 1'b1};
              dir_read <= data[0];
              phase <= TWMR_PH_ADDR;
              state <= TWMR_BIT_LOW;
            end else if (ctrl.stop_request) begin
              sda_oe_o <= 1'b1;
              restart_after_stop <= ctrl.start_request;
              state <= TWMR_STOP_LO;
            end else if (ctrl.start_request) begin
              sda_oe_o <= 1'b0;
              state <= TWMR_RS_LO;
            end else if (code_rx) begin
              tx9 <= {8'hff, !ctrl.ack_enable};
              phase <= TWMR_PH_RXD;
              state <= TWMR_BIT_LOW;
            end else if (code_tx) begin
              tx9 <= {data, 1'b1};
              phase <= TWMR_PH_TXD;
              state <= TWMR_BIT_LOW;
            end else begin
              // Nothing requested at 0x48 or 0x58: end cleanly
              sda_oe_o <= 1'b1;
              restart_after_stop <= 1'b0;
              state <= TWMR_STOP_LO;
            end
          end
        end
        TWMR_BIT_LOW: begin
          if (tick) begin
            sda_oe_o <= !tx9[8];
            state <= TWMR_BIT_SETUP;
          end
        end
        TWMR_BIT_SETUP: begin
          if (tick) begin
            scl_oe_o <= 1'b0;
            state <= TWMR_BIT_RISE;
          end
        end
        TWMR_BIT_RISE: begin
          // Slave may stretch the clock
          if (tick && scl_f) state <= TWMR_BIT_HIGH;
        end
        TWMR_BIT_HIGH: begin
          if (tick) begin
            if (arb_lost) begin
              scl_oe_o <= 1'b0;
              sda_oe_o <= 1'b0;
              own <= 1'b0;
              ev_pulse <= 1'b1;
              ev_code <= `TWMR_SC_ARB_LOST;
              state <= TWMR_PAUSE;
            end else begin
              scl_oe_o <= 1'b1;
              tx9 <= {tx9[7:0], 1'b1};
              bitcnt <= bitcnt + 4'h1;
              if (bitcnt != 4'd8) begin
                rxb <= {rxb[6:0], sda_f};
                state <= TWMR_BIT_LOW;
              end else begin
                ev_pulse <= 1'b1;
                ev_load <= phase == TWMR_PH_RXD;
                ev_data <= rxb;
                ev_code <= byte_code(phase, dir_read,
                                     phase == TWMR_PH_RXD ? !tx9[8] : ack_seen);
                state <= TWMR_PAUSE;
              end
            end
          end
        end
        TWMR_STOP_LO: begin
          if (tick) begin
            scl_oe_o <= 1'b0;
            state <= TWMR_STOP_RISE;
          end
        end
        TWMR_STOP_RISE: begin
          if (tick && scl_f) state <= TWMR_STOP_HI;
        end
        TWMR_STOP_HI: begin
          if (tick) begin
            sda_oe_o <= 1'b0;
            stop_done <= 1'b1;
            own <= 1'b0;
            state <= restart_after_stop ? TWMR_WAIT_FREE : TWMR_IDLE;
          end
        end
        TWMR_RS_LO: begin
          if (tick) begin
            scl_oe_o <= 1'b0;
            state <= TWMR_RS_RISE;
          end
        end
        TWMR_RS_RISE: begin
          // Bus stays owned, no STOP in between
          if (tick && scl_f) begin
            sda_oe_o <= 1'b1;
            state <= TWMR_START_HI;
          end
        end
      endcase
    end
  end

  // Open-drain lines only ever pull low
  always_ff @(posedge mclk_i) begin
    scl_out_o <= 1'b0;
    sda_out_o <= 1'b0;
  end

endmodule // twmr_top

`default_nettype wire

//--- tb/twmr_props.sv
// Port-level assertions for the two-wire master engine
`timescale 1ns/1ps
`default_nettype none
`include "twmr_defines.svh"
module twmr_props #(
  parameter int ADDR_W = 8
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic scl_in_i,
  input wire logic scl_out_o,
  input wire logic scl_oe_o,
  input wire logic sda_in_i,
  input wire logic sda_out_o,
  input wire logic sda_oe_o
);
  // Address decode for the three mapped words
  wire logic mapped = (paddr_i == `TWMR_OFS_CONTROL) || (paddr_i == `TWMR_OFS_STATUS) ||
    (paddr_i == `TWMR_OFS_DATA);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  // ****
  // Register bus
  // ****
  property p_ready_time;
    psel_i && penable_i && !$past(penable_i) |=> pready_o;
  endproperty
  a_ready_time: assert property (p_ready_time) else $error("pready late");
  property p_ready_pulse;
    pready_o |=> !pready_o;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready too long");
  property p_err_unmapped;
    psel_i && penable_i && !pready_o && !mapped |=> pslverr_o && pready_o;
  endproperty
  a_err_unmapped: assert property (p_err_unmapped) else $error("no error on unmapped");
  property p_err_only;
    pslverr_o |-> pready_o && !mapped;
  endproperty
  a_err_only: assert property (p_err_only) else $error("stray pslverr");
  property p_rdata_upper;
    pready_o |-> prdata_i[31:8] == 24'h0;
  endproperty
  a_rdata_upper: assert property (p_rdata_upper) else $error("upper read bits set");
  // ****
  // Bus lines
  // ****
  property p_reset_idle;
    $fell(reset_i) |-> !scl_oe_o && !sda_oe_o && !pready_o;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("lines busy after reset");
  property p_start_free;
    $rose(sda_oe_o) && !scl_oe_o |-> scl_in_i && $past(sda_in_i) && $past(sda_oe_o, 2) == 1'b0;
  endproperty
  a_start_free: assert property (p_start_free) else $error("start on busy bus");
  property p_stop_order;
    $fell(sda_oe_o) && !scl_oe_o |-> $past(scl_oe_o) == 1'b0 && $past(scl_oe_o, 2) == 1'b0;
  endproperty
  a_stop_order: assert property (p_stop_order) else $error("stop not after scl high");
  property p_scl_low_min;
    $rose(scl_oe_o) |-> scl_oe_o [*3];
  endproperty
  a_scl_low_min: assert property (p_scl_low_min) else $error("scl low too short");
  property p_out_zero;
    scl_out_o == 1'b0 && sda_out_o == 1'b0;
  endproperty
  a_out_zero: assert property (p_out_zero) else $error("line driven high");
  // Main scenarios reached
  c_start: cover property ($rose(sda_oe_o) && !scl_oe_o);
  c_stop: cover property ($fell(sda_oe_o) && !scl_oe_o);
  c_err: cover property (pslverr_o);
endmodule // twmr_props
`default_nettype wire

//--- tb/twmr_slave_model.sv
// Behavioural slave transmitter on the two-wire bus
`timescale 1ns/1ps
`default_nettype none
module twmr_slave_model #(
  parameter logic [6:0] OWN_ADDR = 7'h50
) (
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_pull_o
);
  logic [7:0] tx_bytes [4] = '{8'h5a, 8'hc3, 8'h96, 8'h3c};
  logic [7:0] shreg = 8'h00;
  logic active = 1'b0, addr_done = 1'b0, reading = 1'b0, last_ack = 1'b0;
  int bitn = 0, idx = 0;
  initial sda_pull_o = 1'b0;
  // Start restarts the address phase, stop frees the line
  always @(negedge sda_i) if (scl_i === 1'b1) begin
    active = 1'b1;
    bitn = 0;
    addr_done = 1'b0;
    reading = 1'b0;
  end
  always @(posedge sda_i) if (scl_i === 1'b1) begin
    active = 1'b0;
    sda_pull_o = 1'b0;
  end
  // Sample address bits and master acknowledge on rise
  always @(posedge scl_i) if (active) begin
    if (bitn < 8) shreg = {shreg[6:0], sda_i};
    else last_ack = sda_i;
    bitn++;
  end
  // Drive acknowledge or data only while the clock is low
  always @(negedge scl_i) if (active) begin
    sda_pull_o = 1'b0;
    if (bitn == 9) begin
      bitn = 0;
      if (addr_done) begin
        idx++;
        reading = reading && !last_ack; // Master NACK ends sending
      end else begin
        addr_done = 1'b1;
        reading = shreg[0] && shreg[7:1] == OWN_ADDR;
      end
    end
    if (!addr_done && bitn == 8 && shreg[7:1] == OWN_ADDR) sda_pull_o = 1'b1;
    else if (addr_done && reading && bitn < 8) sda_pull_o = !tx_bytes[idx][7 - bitn];
  end
endmodule // twmr_slave_model
`default_nettype wire

//--- tb/tb.sv
// Self-checking bench for the two-wire master engine
`timescale 1ns/1ps
`default_nettype none
`include "twmr_defines.svh"
module tb;
  typedef struct packed {
    logic ld;
    logic [7:0] dat;
    logic [7:0] ctl;
    logic [7:0] st;
    logic rx;
    logic [7:0] dx;
  } twmr_row_t;
  logic mclk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, scl_oe, sda_oe, slave_pull, err;
  int error_cnt = 0, checks_done = 0, cyc = 0;
  // Open-drain lines with pull-ups
  wire logic scl_line = !scl_oe;
  wire logic sda_line = !(sda_oe || slave_pull);
  // Transfer steps: optional data load, control write, expected status and byte
  twmr_row_t rows [8] = '{
    '{1'b0, 8'h00, 8'ha4, 8'h08, 1'b0, 8'h00},
    '{1'b1, 8'ha1, 8'hc4, 8'h40, 1'b0, 8'h00},
    '{1'b0, 8'h00, 8'hc4, 8'h50, 1'b1, 8'h5a},
    '{1'b0, 8'h00, 8'h84, 8'h58, 1'b1, 8'hc3},
    '{1'b0, 8'h00, 8'ha4, 8'h10, 1'b0, 8'h00},
    '{1'b1, 8'hb1, 8'h84, 8'h48, 1'b0, 8'h00},
    '{1'b0, 8'h00, 8'ha4, 8'h10, 1'b0, 8'h00},
    '{1'b1, 8'ha0, 8'h84, 8'h18, 1'b0, 8'h00}};
  twmr_top #(.ADDR_W(8), .QUARTER_CYC(2)) DUT (.mclk_i(mclk), .reset_i(reset), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .scl_in_i(scl_line),
    .scl_out_o(), .scl_oe_o(scl_oe), .sda_in_i(sda_line), .sda_out_o(), .sda_oe_o(sda_oe));
  twmr_slave_model #(.OWN_ADDR(7'h50)) u_slave (.scl_i(scl_line), .sda_i(sda_line),
    .sda_pull_o(slave_pull));
  initial forever #25 mclk = ~mclk;
  // Hang guard
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      close_out();
    end
  end
  task automatic close_out;
    if (error_cnt == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // One APB transfer; read data and error taken at the ready edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_flag(input int b, input logic v);
    do apb(1'b0, `TWMR_OFS_CONTROL, 8'h00); while (rd[b] !== v);
  endtask
  initial begin
    repeat (5) @(posedge mclk);
    reset <= 1'b0;
    apb(1'b0, `TWMR_OFS_CONTROL, 8'h00);
    chk(rd[7:0], `TWMR_CONTROL_RST);
    apb(1'b0, `TWMR_OFS_STATUS, 8'h00);
    chk(rd[7:0], `TWMR_STATUS_RST);
    apb(1'b0, `TWMR_OFS_DATA, 8'h00);
    chk(rd[7:0], `TWMR_DATA_RST);
    apb(1'b1, 8'h0c, 8'h55);
    chk({7'h0, err}, 8'h01);
    // Prescaler bits show in status and must be masked off
    apb(1'b1, `TWMR_OFS_STATUS, 8'h03);
    apb(1'b0, `TWMR_OFS_STATUS, 8'h00);
    chk(rd[7:0], `TWMR_STATUS_RST | 8'h03);
    // Start, read address, bytes, restart, refused address, restart, write address
    foreach (rows[i]) begin
      if (rows[i].ld) apb(1'b1, `TWMR_OFS_DATA, rows[i].dat);
      apb(1'b1, `TWMR_OFS_CONTROL, rows[i].ctl);
      wait_flag(`TWMR_CB_PENDING, 1'b1);
      apb(1'b0, `TWMR_OFS_STATUS, 8'h00);
      chk(rd[7:0] & 8'hf8, rows[i].st);
      if (rows[i].rx) begin
        apb(1'b0, `TWMR_OFS_DATA, 8'h00);
        chk(rd[7:0], rows[i].dx);
      end
    end
    // Zero to the flag must not resume the transfer
    apb(1'b1, `TWMR_OFS_CONTROL, 8'h04);
    repeat (40) @(posedge mclk);
    apb(1'b0, `TWMR_OFS_CONTROL, 8'h00);
    chk(rd[7:0] & 8'h80, 8'h80);
    apb(1'b0, `TWMR_OFS_STATUS, 8'h00);
    chk(rd[7:0] & 8'hf8, `TWMR_SC_AW_ACK);
    apb(1'b1, `TWMR_OFS_CONTROL, 8'h94);
    wait_flag(`TWMR_CB_STOP, 1'b0);
    repeat (8) @(posedge mclk);
    chk({6'h0, scl_line, sda_line}, 8'h03);
    // Data write while idle is refused and flagged
    apb(1'b1, `TWMR_OFS_DATA, 8'h12);
    apb(1'b0, `TWMR_OFS_CONTROL, 8'h00);
    chk(rd[7:0] & 8'h08, 8'h08);
    close_out();
  end
endmodule // tb
bind twmr_top twmr_props #(.ADDR_W(ADDR_W)) u_props (.mclk_i(mclk_i), .reset_i(reset_i),
  .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .pwdata_i(pwdata_i), .prdata_i(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .scl_in_i(scl_in_i), .scl_out_o(scl_out_o), .scl_oe_o(scl_oe_o), .sda_in_i(sda_in_i),
  .sda_out_o(sda_out_o), .sda_oe_o(sda_oe_o));
`default_nettype wire
